/* File: hdl/sems_pkg.sv */
// Package: register map, field layout, operation codes and request carrier
package sems_pkg;
  // Register map, byte offsets
  localparam logic [7:0] SEMS_CMD_OFFSET = 8'hB0;
  localparam logic [7:0] SEMS_DATA_OFFSET = 8'hB4;
  // Command register field layout
  localparam int SEMS_BUSY_BIT = 31;
  localparam int SEMS_OP_LSB = 28;
  localparam int SEMS_OP_W = 3;
  localparam int SEMS_TMO_BIT = 9;
  localparam int SEMS_ADDR_LSB = 0;
  localparam int SEMS_ADDR_W = 8;
  localparam int SEMS_DATA_W = 8;
  // Operation codes
  localparam logic [2:0] SEMS_OP_READ = 3'h0;
  localparam logic [2:0] SEMS_OP_WRITE = 3'h3;
  localparam logic [2:0] SEMS_OP_LOAD = 3'h7;
  // Timeout in its own unit and derived cycle count at 100 MHz
  localparam int SEMS_CLK_MHZ = 100;
  localparam int SEMS_TIMEOUT_US = 1000;
  localparam int SEMS_TIMEOUT_CYC = SEMS_TIMEOUT_US * SEMS_CLK_MHZ;
  localparam logic [31:0] SEMS_ZERO32 = 32'h0000_0000;
  // Request handed to the serial engine
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sems_req_t;
  typedef enum logic [1:0] {SEMS_LOAD, SEMS_IDLE, SEMS_RUN} sems_state_t;
endpackage

/* File: hdl/sems_timer.sv */
// Operation watchdog: counts while an operation runs, pulses on expiry
`timescale 1ns/10ps
module sems_timer
  import sems_pkg::*;
#(
  parameter int TIMEOUT_CYC = SEMS_TIMEOUT_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  output logic expired_o
);
  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);
  logic [CNT_W-1:0] count;

  // Restarts whenever the operation is not running
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count <= '0;
    end
    else if (!run_i || expired_o)
    begin
      count <= '0;
    end
    else
    begin
      count <= count + CNT_W'(1);
    end
  end

  assign expired_o = run_i && (count == LAST);
endmodule

/* File: hdl/sems_ctrl.sv */
// Serial memory command control: command/data registers and operation handshake
//
// Function
// - The command register sits at byte offset B0h and is 32 bits wide.
// - Writing one into bit 31 starts the coded operation at the given address.
// - Bit 31 stays one while the operation runs and clears itself at its end.
// - Read data is valid in the data register when bit 31 clears.
// - A write with no memory attached keeps bit 31 set until the timeout clears it.
// - Bit 31 is one directly after reset with no host action.
// - After reset the station address load runs and bit 31 clears once it ends.
`timescale 1ns/10ps
module sems_ctrl
  import sems_pkg::*;
#(
  parameter int TIMEOUT_CYC = SEMS_TIMEOUT_CYC,
  parameter logic [7:0] LOAD_ADDR = 8'h00
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic mem_req_o,
  output sems_req_t mem_cmd_o,
  input wire logic mem_done_i,
  input wire logic [7:0] mem_rdata_i
);
  sems_state_t state;
  sems_req_t cmd;
  logic [SEMS_OP_W-1:0] cmd_op;
  logic [SEMS_ADDR_W-1:0] cmd_addr;
  logic [SEMS_DATA_W-1:0] data_reg;
  logic timeout_flag;
  logic expired;
  logic cmd_wr;
  logic data_wr;
  logic launch;
  logic finish;
  logic busy;

  // Address decode of the two registers
  assign cmd_wr = reg_wr_i && (reg_addr_i == SEMS_CMD_OFFSET);
  assign data_wr = reg_wr_i && (reg_addr_i == SEMS_DATA_OFFSET);
  assign launch = cmd_wr && reg_wdata_i[SEMS_BUSY_BIT] && (state == SEMS_IDLE);
  assign finish = mem_req_o && (mem_done_i || expired);
  assign busy = (state != SEMS_IDLE);

  // Watchdog for operations that never answer
  sems_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(mem_req_o),
    .expired_o(expired)
  );

  // Sequencer: reset starts in the address load so busy is high at once
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= SEMS_LOAD;
    end
    else
    begin
      unique case (state)
        SEMS_LOAD:
        begin
          if (finish)
          begin
            state <= SEMS_IDLE;
          end
        end
        SEMS_IDLE:
        begin
          if (launch)
          begin
            state <= SEMS_RUN;
          end
        end
        SEMS_RUN:
        begin
          if (finish)
          begin
            state <= SEMS_IDLE;
          end
        end
      endcase
    end
  end

  // Command fields; writes while busy are dropped to protect the running request
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cmd_op <= SEMS_OP_LOAD;
      cmd_addr <= LOAD_ADDR;
    end
    else if (cmd_wr && !busy)
    begin
      cmd_op <= reg_wdata_i[SEMS_OP_LSB +: SEMS_OP_W];
      cmd_addr <= reg_wdata_i[SEMS_ADDR_LSB +: SEMS_ADDR_W];
    end
  end

  // Data register: host write data for writes, memory data on read completion
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      data_reg <= '0;
    end
    else if (mem_req_o && mem_done_i && (cmd.op != SEMS_OP_WRITE))
    begin
      data_reg <= mem_rdata_i;
    end
    else if (data_wr && !busy)
    begin
      data_reg <= reg_wdata_i[SEMS_DATA_W-1:0];
    end
  end
  // Request word built in one place so the struct has a single driver
  assign cmd = {cmd_op, cmd_addr, data_reg};

  // Sticky timeout flag, write one to clear; a new expiry wins over the clear
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      timeout_flag <= 1'b0;
    end
    else if (expired && mem_req_o)
    begin
      timeout_flag <= 1'b1;
    end
    else if (cmd_wr && reg_wdata_i[SEMS_TMO_BIT])
    begin
      timeout_flag <= 1'b0;
    end
  end

  // Registered read data, unmapped offsets read zero
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= SEMS_ZERO32;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= SEMS_ZERO32;
      if (reg_addr_i == SEMS_CMD_OFFSET)
      begin
        reg_rdata_o[SEMS_BUSY_BIT] <= busy;
        reg_rdata_o[SEMS_OP_LSB +: SEMS_OP_W] <= cmd.op;
        reg_rdata_o[SEMS_ADDR_LSB +: SEMS_ADDR_W] <= cmd.addr;
        reg_rdata_o[SEMS_TMO_BIT] <= timeout_flag;
      end
      else if (reg_addr_i == SEMS_DATA_OFFSET)
      begin
        reg_rdata_o[SEMS_DATA_W-1:0] <= data_reg;
      end
    end
  end

  // Request to the engine is a level held for the whole operation
  assign mem_req_o = busy;
  assign mem_cmd_o = cmd;

  // Assertions
  sequence s_launch;
    cmd_wr && reg_wdata_i[SEMS_BUSY_BIT] && !busy;
  endsequence
  sequence s_busy_req;
    busy && mem_req_o;
  endsequence

  property p_launch;
    @(posedge clk_i) disable iff (reset_i)
    s_launch |=> s_busy_req ##0
      (mem_cmd_o.op == $past(reg_wdata_i[SEMS_OP_LSB +: SEMS_OP_W]));
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not start op");

  property p_offset;
    @(posedge clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i != SEMS_CMD_OFFSET && !busy) |=> !busy;
  endproperty
  a_offset: assert property (p_offset) else $error("launch from wrong offset");

  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
    (busy && !mem_done_i && !expired) |=> busy && $stable(mem_cmd_o.op);
  endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");

  property p_done;
    @(posedge clk_i) disable iff (reset_i)
    (busy && mem_done_i) |=> !busy;
  endproperty
  a_done: assert property (p_done) else $error("busy not cleared at done");

  property p_rdata;
    @(posedge clk_i) disable iff (reset_i)
    (busy && mem_done_i && mem_cmd_o.op == SEMS_OP_READ) |=>
      (!busy && data_reg == $past(mem_rdata_i));
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not captured");

  property p_timeout;
    @(posedge clk_i) disable iff (reset_i)
    (busy && expired) |=> (!busy && timeout_flag);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not handled");

  property p_reset_busy;
    @(posedge clk_i)
    $past(reset_i) |-> (busy && mem_cmd_o.op == SEMS_OP_LOAD);
  endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("busy low after reset");

  property p_load_end;
    @(posedge clk_i) disable iff (reset_i)
    (state == SEMS_LOAD && !mem_done_i && !expired) |=> (state == SEMS_LOAD);
  endproperty
  a_load_end: assert property (p_load_end) else $error("load left early");

  property p_flag_sticky;
    @(posedge clk_i) disable iff (reset_i)
    (timeout_flag && !(cmd_wr && reg_wdata_i[SEMS_TMO_BIT])) |=> timeout_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
endmodule

/* File: tb/sems_mem_model.sv */
// Serial memory engine model: answers each request after a set delay
`timescale 1ns/10ps
module sems_mem_model
  import sems_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic mem_req_i,
  input sems_req_t mem_cmd_i,
  input wire logic absent_i,
  input wire logic [7:0] delay_i,
  output logic mem_done_o,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem [256];
  // Known contents so every address reads back a distinct byte, then
  // one answer per request; an absent memory never answers
  initial
  begin
    mem_done_o = 1'b0;
    mem_rdata_o = 8'h5A;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hC3;
    forever
    begin
      @(posedge clk_i iff (mem_req_i && !reset_i && !absent_i));
      repeat (delay_i) @(posedge clk_i);
      #1;
      mem_done_o = 1'b1;
      mem_rdata_o = mem[mem_cmd_i.addr];
      if (mem_cmd_i.op == SEMS_OP_WRITE)
        mem[mem_cmd_i.addr] = mem_cmd_i.wdata;
      @(posedge clk_i);
      #1;
      mem_done_o = 1'b0;
      mem_rdata_o = ~mem_rdata_o; // Stale byte must not pass for data
      wait (!mem_req_i);
    end
  end
endmodule

/* File: tb/test_serial_eeprom_command_control.sv */
// Testbench for the serial memory command control block
`timescale 1ns/10ps
module test_serial_eeprom_command_control
  import sems_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic mem_req_o;
  sems_req_t mem_cmd_o;
  logic mem_done_i;
  logic [7:0] mem_rdata_i;
  logic absent = 1'b0;
  logic [31:0] rd;
  int errors = 0;
  int num_checks = 0;

  sems_ctrl #(.TIMEOUT_CYC(20)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
    .mem_cmd_o(mem_cmd_o), .mem_done_i(mem_done_i), .mem_rdata_i(mem_rdata_i));
  sems_mem_model mem_u (.clk_i(clk_i), .reset_i(reset_i), .mem_req_i(mem_req_o),
    .mem_cmd_i(mem_cmd_o), .absent_i(absent), .delay_i(8'h08),
    .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i));

  // 100 MHz clock
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rd = reg_rdata_o; // Registered answer, landed at the taking edge
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  // Poll the busy bit under a bounded count
  task automatic wait_idle();
    for (int i = 0; i < 40; i++)
    begin
      acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
      if (rd[31] === 1'b0)
        return;
    end
    chk("busy clear", 32'h0, 32'h1);
  endtask

  task automatic launch(input logic [2:0] op, input logic [7:0] a);
    acc(SEMS_CMD_OFFSET, 1'b1, {1'b1, op, 20'h00000, a});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #50000;
    errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    // Reset load: busy at once, then loaded byte
    acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
    chk("busy after reset", 32'h1, 32'(rd[31]));
    wait_idle();
    acc(SEMS_DATA_OFFSET, 1'b0, 32'h0);
    chk("load data", 32'h0000_00C3, 32'(rd[7:0]));
    $display("test reset load done");
    // Write then read back through the memory; busy checked while the write runs
    acc(SEMS_DATA_OFFSET, 1'b1, 32'h0000_003C);
    launch(SEMS_OP_WRITE, 8'h05);
    acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
    chk("busy during write", 32'h1, 32'(rd[31]));
    wait_idle();
    // Data register cleared first so only a real read can bring the byte back
    acc(SEMS_DATA_OFFSET, 1'b1, 32'h0000_0000);
    launch(SEMS_OP_READ, 8'h05);
    wait_idle();
    acc(SEMS_DATA_OFFSET, 1'b0, 32'h0);
    chk("read data", 32'h0000_003C, 32'(rd[7:0]));
    launch(SEMS_OP_READ, 8'h07);
    wait_idle();
    acc(SEMS_DATA_OFFSET, 1'b0, 32'h0);
    chk("read untouched byte", 32'h0000_00C4, 32'(rd[7:0]));
    acc(8'h40, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, rd);
    $display("test write read done");
    // No memory attached: busy until timeout, then flag
    absent = 1'b1;
    launch(SEMS_OP_WRITE, 8'h06);
    repeat (12) @(posedge clk_i);
    acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
    chk("busy before timeout", 32'h1, 32'(rd[31]));
    repeat (10) @(posedge clk_i);
    acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
    chk("busy and flag after timeout", 32'h1, 32'({rd[31], rd[9]}));
    acc(SEMS_CMD_OFFSET, 1'b1, 32'h0000_0200);
    acc(SEMS_CMD_OFFSET, 1'b0, 32'h0);
    chk("flag cleared", 32'h0, 32'(rd[9]));
    absent = 1'b0;
    $display("test timeout done");
    tally_and_finish();
  end
endmodule
